/* src/pif_flag_next.sv */
// Purpose: Next value of eight software-cleared sticky flags
// Assumes: Set and clear vectors are one-cycle terms
// Notes: Set has priority over clear
`timescale 1ns/1ns
module pif_flag_next (
    input wire logic [7:0] cur,
    input wire logic [7:0] set,
    input wire logic [7:0] clr,
    input wire logic [7:0] impl,
    output logic [7:0] nxt
);
    generate
        for (genvar i = 0; i < 8; i++) begin : g_bit
            // Event in the clearing cycle is kept
            assign nxt[i] = impl[i] & (set[i] | (cur[i] & ~clr[i])); // [R1] [R14]
        end
    endgenerate
endmodule : pif_flag_next

/* src/pif_flag_regs.sv */
// Purpose: Two peripheral interrupt flag registers with APB access and interrupt
// Assumes: Event pulses and serial levels synchronous to pclk
// Notes: Zero wait state APB; unmapped addresses answer with pslverr
`timescale 1ns/1ns
module pif_flag_regs #(
    parameter bit HAS_PARALLEL_PORT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pif_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pif_pkg::pif_evt_s evt,
    input wire pif_pkg::pif_serial_s serial,
    input wire pif_pkg::pif_ccp_mode_e ccp1_mode,
    input wire pif_pkg::pif_ccp_mode_e ccp2_mode,
    output logic [7:0] peripheral_flags_one,
    output logic [7:0] peripheral_flags_two,
    output logic irq
);

    pif_pkg::pif_state_s s_r;
    pif_pkg::pif_state_s s_nxt;

    logic setup;
    logic access;
    logic wr;
    logic hit;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [7:0] clr_one;
    logic [7:0] clr_two;
    logic [7:0] impl_one;
    logic [7:0] one_nxt;
    logic [7:0] two_nxt;
    logic [15:0] w1c;

    assign setup = psel & ~penable;
    assign access = psel & penable & s_r.pready;
    assign wr = access & pwrite;
    assign hit = (paddr == pif_pkg::ADDR_FLAGS_ONE) | (paddr == pif_pkg::ADDR_FLAGS_TWO)
               | (paddr == pif_pkg::ADDR_IRQ_STATUS) | (paddr == pif_pkg::ADDR_IRQ_MASK);

    // Parallel port flag absent on small packages
    assign impl_one = {HAS_PARALLEL_PORT, 7'h7f}; // [R4]

    // Events set flags with no regard to any enable
    always_comb begin
        set_one = 8'h00;
        set_one[pif_pkg::B1_PARALLEL] = evt.parallel_access; // [R1] [R3]
        set_one[pif_pkg::B1_CONV] = evt.conv_done; // [R5]
        set_one[pif_pkg::B1_SYNC] = evt.sync_serial_done; // [R8]
        // Capture/compare flag is unused in PWM mode
        set_one[pif_pkg::B1_CCP1] = evt.ccp1_event & (ccp1_mode != pif_pkg::CCP_PWM); // [R9]
        set_one[pif_pkg::B1_TMR2] = evt.tmr2_match; // [R10]
        set_one[pif_pkg::B1_TMR1] = evt.tmr1_overflow; // [R11]
        set_two = 8'h00;
        set_two[pif_pkg::B2_CLK_FAIL] = evt.clock_fail; // [R12]
        set_two[pif_pkg::B2_CMP] = evt.cmp_change; // [R13]
        set_two[pif_pkg::B2_NV_WRITE] = evt.nv_write_done; // [R13]
        set_two[pif_pkg::B2_BUS_COLL] = evt.bus_collision; // [R13]
        set_two[pif_pkg::B2_VOLT] = evt.voltage_detect; // [R13]
        set_two[pif_pkg::B2_TMR3] = evt.tmr3_overflow; // [R13]
        set_two[pif_pkg::B2_CCP2] = evt.ccp2_event & (ccp2_mode != pif_pkg::CCP_PWM); // [R13]
    end

    // A written zero clears; a written one leaves the flag alone
    assign clr_one = (wr && paddr == pif_pkg::ADDR_FLAGS_ONE) ? ~pwdata[7:0] : 8'h00; // [R14]
    assign clr_two = (wr && paddr == pif_pkg::ADDR_FLAGS_TWO) ? ~pwdata[7:0] : 8'h00; // [R14]
    assign w1c = (wr && paddr == pif_pkg::ADDR_IRQ_STATUS) ? pwdata[15:0] : 16'h0000;

    pif_flag_next u_next_one (
        .cur(s_r.flags_one),
        .set(set_one),
        .clr(clr_one),
        .impl(impl_one),
        .nxt(one_nxt)
    );

    pif_flag_next u_next_two (
        .cur(s_r.flags_two),
        .set(set_two),
        .clr(clr_two),
        .impl(pif_pkg::FLAGS_TWO_IMPL),
        .nxt(two_nxt)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.pready = setup;
        s_nxt.pslverr = setup & ~hit;
        if (setup) begin
            case (paddr)
                pif_pkg::ADDR_FLAGS_ONE: begin
                    s_nxt.prdata = {24'h000000, s_r.flags_one};
                end
                pif_pkg::ADDR_FLAGS_TWO: begin
                    s_nxt.prdata = {24'h000000, s_r.flags_two};
                end
                pif_pkg::ADDR_IRQ_STATUS: begin
                    s_nxt.prdata = {16'h0000, s_r.irq_status};
                end
                pif_pkg::ADDR_IRQ_MASK: begin
                    s_nxt.prdata = {16'h0000, s_r.irq_mask};
                end
                default: begin
                    s_nxt.prdata = 32'h00000000;
                end
            endcase
        end
        s_nxt.flags_one = one_nxt;
        // Serial flags mirror the buffer state; writes cannot touch them
        s_nxt.flags_one[pif_pkg::B1_RX_FULL] = serial.rx_full & ~serial.rx_buffer_read; // [R6]
        s_nxt.flags_one[pif_pkg::B1_TX_EMPTY] = serial.tx_empty & ~serial.tx_buffer_write; // [R7]
        s_nxt.flags_two = two_nxt;
        // Rising flags latch into status; a rise beats a same-cycle clear
        s_nxt.irq_status = ({s_nxt.flags_two, s_nxt.flags_one} & ~{s_r.flags_two, s_r.flags_one})
                         | (s_r.irq_status & ~w1c);
        if (wr && paddr == pif_pkg::ADDR_IRQ_MASK) begin
            s_nxt.irq_mask = pwdata[15:0];
        end
        s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.prdata <= 32'h00000000;
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
            s_r.irq <= 1'b0;
            s_r.flags_one <= pif_pkg::FLAGS_RST; // [R14]
            s_r.flags_two <= pif_pkg::FLAGS_RST; // [R14]
            s_r.irq_status <= pif_pkg::IRQ_STATUS_RST;
            s_r.irq_mask <= pif_pkg::IRQ_MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;
    assign peripheral_flags_one = s_r.flags_one;
    assign peripheral_flags_two = s_r.flags_two;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_event_polls;
        evt.conv_done |=> peripheral_flags_one[pif_pkg::B1_CONV];
    endproperty
    a_event_polls: assert property (p_event_polls) // [R1] [R5]
        else $error("conversion flag not set after event");

    property p_parallel_sticky;
        HAS_PARALLEL_PORT && evt.parallel_access
            |=> peripheral_flags_one[pif_pkg::B1_PARALLEL]
                ##1 (peripheral_flags_one[pif_pkg::B1_PARALLEL] || $past(wr));
    endproperty
    a_parallel_sticky: assert property (p_parallel_sticky) // [R3]
        else $error("parallel port flag lost without a write");

    property p_parallel_absent;
        !HAS_PARALLEL_PORT |-> !peripheral_flags_one[pif_pkg::B1_PARALLEL];
    endproperty
    a_parallel_absent: assert property (p_parallel_absent) // [R4]
        else $error("absent parallel port flag reads one");

    property p_rx_mirror;
        serial.rx_buffer_read || !serial.rx_full |=> !peripheral_flags_one[pif_pkg::B1_RX_FULL];
    endproperty
    a_rx_mirror: assert property (p_rx_mirror) // [R6]
        else $error("receive flag still set after buffer read");

    property p_tx_mirror;
        serial.tx_empty && !serial.tx_buffer_write
            |=> peripheral_flags_one[pif_pkg::B1_TX_EMPTY];
    endproperty
    a_tx_mirror: assert property (p_tx_mirror) // [R7]
        else $error("transmit empty flag not shown");

    property p_sync_done;
        evt.sync_serial_done |=> peripheral_flags_one[pif_pkg::B1_SYNC];
    endproperty
    a_sync_done: assert property (p_sync_done) // [R8]
        else $error("sync serial flag not set");

    property p_ccp1_cause;
        $rose(peripheral_flags_one[pif_pkg::B1_CCP1])
            |-> $past(evt.ccp1_event) && $past(ccp1_mode) != pif_pkg::CCP_PWM;
    endproperty
    a_ccp1_cause: assert property (p_ccp1_cause) // [R9]
        else $error("capture/compare flag rose without a valid event");

    property p_tmr2;
        evt.tmr2_match |=> peripheral_flags_one[pif_pkg::B1_TMR2];
    endproperty
    a_tmr2: assert property (p_tmr2) // [R10]
        else $error("timer2 match flag not set");

    property p_tmr1_hold;
        peripheral_flags_one[pif_pkg::B1_TMR1] && !(wr && paddr == pif_pkg::ADDR_FLAGS_ONE)
            |=> peripheral_flags_one[pif_pkg::B1_TMR1];
    endproperty
    a_tmr1_hold: assert property (p_tmr1_hold) // [R11]
        else $error("timer1 flag dropped without software clear");

    property p_clock_fail;
        evt.clock_fail |=> peripheral_flags_two[pif_pkg::B2_CLK_FAIL];
    endproperty
    a_clock_fail: assert property (p_clock_fail) // [R12]
        else $error("clock fail flag not set");

    property p_two_unused;
        !peripheral_flags_two[pif_pkg::B2_UNUSED];
    endproperty
    a_two_unused: assert property (p_two_unused) // [R13]
        else $error("unused bit of second register is set");

    property p_write_zero_clears;
        wr && paddr == pif_pkg::ADDR_FLAGS_TWO && !pwdata[pif_pkg::B2_TMR3] && !evt.tmr3_overflow
            |=> !peripheral_flags_two[pif_pkg::B2_TMR3];
    endproperty
    a_write_zero_clears: assert property (p_write_zero_clears) // [R14]
        else $error("written zero did not clear flag");

    property p_conv_sticky;
        peripheral_flags_one[pif_pkg::B1_CONV]
            && !(wr && paddr == pif_pkg::ADDR_FLAGS_ONE && !pwdata[pif_pkg::B1_CONV])
            |=> peripheral_flags_one[pif_pkg::B1_CONV];
    endproperty
    a_conv_sticky: assert property (p_conv_sticky) // [R5]
        else $error("conversion flag dropped without software clear");

    property p_sync_sticky;
        peripheral_flags_one[pif_pkg::B1_SYNC]
            && !(wr && paddr == pif_pkg::ADDR_FLAGS_ONE && !pwdata[pif_pkg::B1_SYNC])
            |=> peripheral_flags_one[pif_pkg::B1_SYNC];
    endproperty
    a_sync_sticky: assert property (p_sync_sticky) // [R8]
        else $error("sync serial flag dropped without software clear");

    property p_clock_fail_sticky;
        peripheral_flags_two[pif_pkg::B2_CLK_FAIL]
            && !(wr && paddr == pif_pkg::ADDR_FLAGS_TWO && !pwdata[pif_pkg::B2_CLK_FAIL])
            |=> peripheral_flags_two[pif_pkg::B2_CLK_FAIL];
    endproperty
    a_clock_fail_sticky: assert property (p_clock_fail_sticky) // [R12]
        else $error("clock fail flag dropped without software clear");

    property p_ccp1_pwm_gate;
        evt.ccp1_event && ccp1_mode == pif_pkg::CCP_PWM
            && !peripheral_flags_one[pif_pkg::B1_CCP1]
            |=> !peripheral_flags_one[pif_pkg::B1_CCP1];
    endproperty
    a_ccp1_pwm_gate: assert property (p_ccp1_pwm_gate) // [R9]
        else $error("capture/compare flag set in PWM mode");

    property p_cmp_change;
        evt.cmp_change |=> peripheral_flags_two[pif_pkg::B2_CMP];
    endproperty
    a_cmp_change: assert property (p_cmp_change) // [R13]
        else $error("comparator change flag not set");

    property p_nv_write;
        evt.nv_write_done |=> peripheral_flags_two[pif_pkg::B2_NV_WRITE];
    endproperty
    a_nv_write: assert property (p_nv_write) // [R13]
        else $error("nonvolatile write flag not set");

    property p_bus_coll;
        evt.bus_collision |=> peripheral_flags_two[pif_pkg::B2_BUS_COLL];
    endproperty
    a_bus_coll: assert property (p_bus_coll) // [R13]
        else $error("bus collision flag not set");

    property p_volt;
        evt.voltage_detect |=> peripheral_flags_two[pif_pkg::B2_VOLT];
    endproperty
    a_volt: assert property (p_volt) // [R13]
        else $error("voltage detect flag not set");

    property p_tmr3;
        evt.tmr3_overflow |=> peripheral_flags_two[pif_pkg::B2_TMR3];
    endproperty
    a_tmr3: assert property (p_tmr3) // [R13]
        else $error("timer3 overflow flag not set");

    property p_ccp2_event;
        evt.ccp2_event && ccp2_mode != pif_pkg::CCP_PWM
            |=> peripheral_flags_two[pif_pkg::B2_CCP2];
    endproperty
    a_ccp2_event: assert property (p_ccp2_event) // [R13]
        else $error("second capture/compare flag not set");

    property p_reset_zero;
        $rose(presetn) |-> peripheral_flags_one == pif_pkg::FLAGS_RST
            && peripheral_flags_two == pif_pkg::FLAGS_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero) // [R14]
        else $error("flags not zero after reset");

    property p_irq_level;
        irq == |(s_r.irq_status & s_r.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt output disagrees with status and mask");

    property p_zero_wait;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("bus answer not in first access cycle");

endmodule : pif_flag_regs

/* src/pif_pkg.sv */
// Purpose: Shared constants and types for the peripheral interrupt flag registers
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Functional notes below use tags R1..R14
//
// Functional notes
// R1: Flags set on events regardless of enables
// R2: Software clears flag before enable and after service
// R3: Bit 7 sets on parallel port access
// R4: Parallel port flag reads zero when absent
// R5: Bit 6 sets on conversion done, sticky
// R6: Bit 5 read-only, receive full, clears on read
// R7: Bit 4 read-only, transmit empty, clears on write
// R8: Bit 3 sets on sync serial done, sticky
// R9: Bit 2 capture/compare event, not PWM
// R10: Bit 1 sets on timer2 period match
// R11: Bit 0 sets on timer1 overflow, sticky
// R12: Second bit 7 sets on oscillator fail
// R13: Second register event flags, bit 5 zero
// R14: Reset to zero, written zero clears flag
package pif_pkg;

    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_ONE = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_TWO = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h00c;

    // First register bit positions
    localparam int B1_PARALLEL = 7;
    localparam int B1_CONV = 6;
    localparam int B1_RX_FULL = 5;
    localparam int B1_TX_EMPTY = 4;
    localparam int B1_SYNC = 3;
    localparam int B1_CCP1 = 2;
    localparam int B1_TMR2 = 1;
    localparam int B1_TMR1 = 0;
    // Second register bit positions
    localparam int B2_CLK_FAIL = 7;
    localparam int B2_CMP = 6;
    localparam int B2_UNUSED = 5;
    localparam int B2_NV_WRITE = 4;
    localparam int B2_BUS_COLL = 3;
    localparam int B2_VOLT = 2;
    localparam int B2_TMR3 = 1;
    localparam int B2_CCP2 = 0;

    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] IRQ_STATUS_RST = 16'h0000;
    localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
    localparam logic [7:0] FLAGS_TWO_IMPL = 8'hdf;

    typedef enum logic [1:0] {
        CCP_CAPTURE,
        CCP_COMPARE,
        CCP_PWM
    } pif_ccp_mode_e;

    // One-cycle event pulses from the peripherals
    typedef struct packed {
        logic parallel_access;
        logic conv_done;
        logic sync_serial_done;
        logic ccp1_event;
        logic tmr2_match;
        logic tmr1_overflow;
        logic clock_fail;
        logic cmp_change;
        logic nv_write_done;
        logic bus_collision;
        logic voltage_detect;
        logic tmr3_overflow;
        logic ccp2_event;
    } pif_evt_s;

    // Serial buffer levels and strobes
    typedef struct packed {
        logic rx_full;
        logic rx_buffer_read;
        logic tx_empty;
        logic tx_buffer_write;
    } pif_serial_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [7:0] flags_one;
        logic [7:0] flags_two;
        logic [15:0] irq_status;
        logic [15:0] irq_mask;
    } pif_state_s;

endpackage : pif_pkg

/* verification/pif_periph_model.sv */
// Purpose: Peripheral side model driving event pulses and serial buffer levels
// Assumes: Bench requests are one-cycle pulses launched after a rising edge
// Notes: Buffer levels move only at an edge, as a real serial port would
`timescale 1ns/1ns
module pif_periph_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [12:0] fire,
    input wire logic [3:0] ser_cmd,
    output pif_pkg::pif_evt_s evt,
    output pif_pkg::pif_serial_s serial
);
    logic rx_full_r;
    logic tx_empty_r;
    // Order of ser_cmd: receive fill, receive read, transmit write, transmit drained
    assign evt = pif_pkg::pif_evt_s'(fire);
    assign serial = pif_pkg::pif_serial_s'({rx_full_r, ser_cmd[2], tx_empty_r, ser_cmd[1]});
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_r <= 1'b0;
            tx_empty_r <= 1'b1;
        end else begin
            rx_full_r <= ser_cmd[3] | (rx_full_r & ~ser_cmd[2]);
            tx_empty_r <= ser_cmd[0] | (tx_empty_r & ~ser_cmd[1]);
        end
    end
endmodule : pif_periph_model

/* verification/tb.sv */
// Purpose: Random and directed check of the peripheral flag registers
// Assumes: Zero wait APB slave, events one cycle wide
// Notes: Expected flags and status come from a bench-side model
`timescale 1ns/1ns
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [12:0] fire = '0;
    logic [3:0] ser_cmd = '0;
    pif_pkg::pif_ccp_mode_e m1 = pif_pkg::CCP_CAPTURE;
    pif_pkg::pif_ccp_mode_e m2 = pif_pkg::CCP_CAPTURE;
    pif_pkg::pif_evt_s evt;
    pif_pkg::pif_serial_s serial;
    logic [7:0] f1;
    logic [7:0] f2;
    logic [7:0] g1;
    logic irq;
    logic [15:0] ef = 16'h0010;
    logic [15:0] es = 16'h0010;
    logic [15:0] em = 16'h0000;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int comparisons = 0;
    int seed = 32'h996a;

    always #2 pclk = ~pclk;

    pif_periph_model pm (.pclk(pclk), .presetn(presetn), .fire(fire), .ser_cmd(ser_cmd),
        .evt(evt), .serial(serial));
    pif_flag_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .serial(serial), .ccp1_mode(m1), .ccp2_mode(m2),
        .peripheral_flags_one(f1), .peripheral_flags_two(f2), .irq(irq));
    // Package variant without the parallel port, same traffic
    pif_flag_regs #(.HAS_PARALLEL_PORT(1'b0)) uut_np (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(), .pready(), .pslverr(), .evt(evt), .serial(serial), .ccp1_mode(m1),
        .ccp2_mode(m2), .peripheral_flags_one(g1), .peripheral_flags_two(), .irq());

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
        check(32'(er), 32'h0);
    endtask : rdchk

    function automatic logic [15:0] evb(input logic [12:0] v);
        evb = {v[6:5], 1'b0, v[4:1], v[0] & (m2 != pif_pkg::CCP_PWM),
            v[12:11], 2'b00, v[10], v[9] & (m1 != pif_pkg::CCP_PWM), v[8:7]};
    endfunction : evb

    task automatic step(input logic [12:0] v, input logic [3:0] sc, input logic [1:0] a,
        input logic [1:0] b);
        logic [15:0] old;
        old = ef;
        @(posedge pclk);
        fire <= v;
        ser_cmd <= sc;
        m1 <= pif_pkg::pif_ccp_mode_e'(a);
        m2 <= pif_pkg::pif_ccp_mode_e'(b);
        @(posedge pclk);
        fire <= '0;
        ser_cmd <= '0;
        @(posedge pclk);
        @(negedge pclk);
        ef = ef | evb(v);
        ef[5] = sc[3] | (ef[5] & ~sc[2]);
        ef[4] = sc[0] | (ef[4] & ~sc[1]);
        es = es | (ef & ~old);
        check(32'({f2, f1}), 32'(ef));
        check(32'(g1), {24'h0, 1'b0, ef[6:0]});
        check(32'(irq), 32'(|(es & em)));
    endtask : step

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    initial begin
        logic [31:0] r;
        logic [31:0] w;
        repeat (3) @(posedge pclk);
        check(32'({f2, f1}), 32'h0);
        presetn <= 1'b1;
        apb(1'b0, 12'h010, 32'h0);
        check(32'(er), 32'h1);
        check(rd, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        step(13'h0, 4'h0, 2'd0, 2'd0);
        $display("test reset and unmapped done");
        // Every event in each capture/compare mode, PWM must gate the capture/compare flags
        for (int k = 2; k >= 0; k--) begin
            step(13'h1fff, 4'h0, 2'(k), 2'(k));
            apb(1'b1, pif_pkg::ADDR_FLAGS_ONE, 32'hffff_ff00);
            apb(1'b1, pif_pkg::ADDR_FLAGS_TWO, 32'h0);
            ef = ef & 16'h0030;
            rdchk(pif_pkg::ADDR_FLAGS_ONE, {24'h0, ef[7:0]});
            rdchk(pif_pkg::ADDR_FLAGS_TWO, 32'h0);
        end
        $display("test modes done");
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            w = $random(seed);
            step(r[28:16] & r[31:19], {r[0] & ~ef[5], r[1] & ef[5], r[2] & ef[4],
                r[3] & ~ef[4]}, r[5:4] % 2'd3, r[7:6] % 2'd3);
            case (r[10:8])
                3'd0: begin
                    apb(1'b1, pif_pkg::ADDR_FLAGS_ONE, w);
                    ef[7:0] = ef[7:0] & (w[7:0] | 8'h30);
                end
                3'd1: begin
                    apb(1'b1, pif_pkg::ADDR_FLAGS_TWO, w);
                    ef[15:8] = ef[15:8] & w[7:0];
                end
                3'd2: begin
                    apb(1'b1, pif_pkg::ADDR_IRQ_STATUS, w);
                    es = es & ~w[15:0];
                end
                3'd3: begin
                    apb(1'b1, pif_pkg::ADDR_IRQ_MASK, w);
                    em = w[15:0];
                end
                3'd4: begin
                    rdchk(pif_pkg::ADDR_FLAGS_ONE, {24'h0, ef[7:0]});
                    rdchk(pif_pkg::ADDR_FLAGS_TWO, {24'h0, ef[15:8]});
                    rdchk(pif_pkg::ADDR_IRQ_STATUS, {16'h0, es});
                    rdchk(pif_pkg::ADDR_IRQ_MASK, {16'h0, em});
                end
                default: begin
                end
            endcase
        end
        $display("test random done");
        // Second reset in mid-run, serial model restarts with an empty transmit buffer
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check(32'({f2, f1}), 32'h0);
        presetn <= 1'b1;
        ef = 16'h0010;
        es = 16'h0010;
        em = 16'h0000;
        step(13'h0, 4'h0, 2'd0, 2'd0);
        rdchk(pif_pkg::ADDR_IRQ_MASK, 32'h0);
        rdchk(pif_pkg::ADDR_IRQ_STATUS, {16'h0, es});
        $display("test mid-run reset done");
        final_report();
    end
endmodule : tb
